// file: pkg/qsf_pkg.sv
// qsf_pkg: constants for the quad switch fault interrogation host.
// assumes a 250 MHz system clock; times are in microseconds.
package qsf_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ          = 250;  // system clock rate
   localparam int T_RESET_US       = 100;  // status reset delay wait, chosen margin
   localparam int T_OC_US          = 55;   // overcurrent_sense_delay
   localparam int T_SOFT_US        = 2200; // soft open report delay (2.2 ms)
   localparam int T_ON_US          = 100;  // on-state status delay wait, chosen margin
   localparam int T_SETTLE_US      = 3000; // per-input probe window, covers soft open
   localparam int RESET_CYC        = T_RESET_US * CLK_MHZ;
   localparam int SETTLE_CYC       = T_SETTLE_US * CLK_MHZ;
   localparam int CNT_W            = 20;   // counter width, holds 750000
   // ------------------------------------------------------------
   // result codes
   // ------------------------------------------------------------
   localparam logic [1:0] KIND_NONE = 2'h0; // no fault found
   localparam logic [1:0] KIND_OC   = 2'h1; // overcurrent or soft open
   localparam logic [1:0] KIND_OL   = 2'h2; // open load
   localparam logic [1:0] KIND_UNK  = 2'h3; // not located
   typedef enum logic [2:0] {QSF_IDLE, QSF_CLEAR, QSF_PROBE_ON, QSF_PROBE_OFF, QSF_DONE} qsf_state_e;
endpackage

// file: verilog/qsf_host.sv
// qsf_host: host-side driver and fault interrogation sequencer for a
// quad low-side switch. assumes the fault line is already synchronous.
`timescale 1ns/1ps
`default_nettype none
module qsf_host
   import qsf_pkg::*;
#(
   parameter int RESET_WAIT  = RESET_CYC,  // status reset delay in cycles
   parameter int SETTLE_WAIT = SETTLE_CYC  // probe window in cycles
)(
   input  wire logic       clk,           // 250 MHz
   input  wire logic       rst,           // sync, active high
   input  wire logic [3:0] user_on,       // normal single drive request
   input  wire logic [1:0] user_pair_on,  // normal pair drive request
   input  wire logic       user_pair_mode,// select pair control
   input  wire logic       fault_n,       // shared fault status line
   output logic      [3:0] drive_in,      // individual inputs
   output logic      [1:0] drive_pair,    // pair inputs
   output logic            pair_sel,      // single/dual select
   output logic            busy,          // interrogation running
   output logic            done,          // one-cycle result pulse
   output logic      [1:0] fault_kind,    // result type
   output logic      [1:0] fault_index,   // output or pair index
   output logic            fault_is_pair  // index names a pair
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   qsf_state_e         state;    // sequencer state
   logic [CNT_W-1:0]   cnt;      // delay counter
   logic [1:0]         idx;      // input under probe
   logic               mode;     // pair mode latched at start
   logic               is_oc;    // classification result

   // last probe index depends on mode
   function automatic logic last_idx(input logic m, input logic [1:0] i);
      last_idx = m ? (i == 2'h1) : (i == 2'h3);
   endfunction

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   // a low fault line starts interrogation; the device itself merges all
   // fault types onto it, so classification is by sequencing only
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= QSF_IDLE;
         cnt   <= '0;
         idx   <= 2'h0;
         mode  <= 1'b0;
         is_oc <= 1'b0;
      end else begin
         case (state)
            QSF_IDLE: begin
               cnt <= '0;
               if (!fault_n) begin
                  mode  <= user_pair_mode;
                  state <= QSF_CLEAR;
               end
            end
            // all inputs low, wait the reset delay, then sample
            QSF_CLEAR: begin
               if (cnt == CNT_W'(RESET_WAIT - 1)) begin
                  is_oc <= fault_n;
                  cnt   <= '0;
                  idx   <= 2'h0;
                  state <= QSF_PROBE_ON;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            // one input on; window long enough for the soft open delay
            QSF_PROBE_ON: begin
               if (cnt == CNT_W'(SETTLE_WAIT - 1)) begin
                  cnt   <= '0;
                  state <= QSF_PROBE_OFF;
               end else begin
                  cnt <= cnt + 1'b1;
               end
               // first fault seen while on marks the culprit
               if (is_oc && !fault_n) begin
                  state <= QSF_DONE;
               end
            end
            // off again; open-load line must recover low before next probe
            QSF_PROBE_OFF: begin
               if (cnt == CNT_W'(RESET_WAIT - 1)) begin
                  cnt <= '0;
                  if (last_idx(mode, idx)) begin
                     state <= QSF_DONE;
                  end else begin
                     idx   <= idx + 2'h1;
                     state <= QSF_PROBE_ON;
                  end
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            QSF_DONE: begin
               state <= QSF_IDLE;
            end
            default: state <= QSF_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // open-load locate: line high while probed input on clears suspect
   // ------------------------------------------------------------
   logic [3:0] ol_cand; // outputs still suspected of open load
   always_ff @(posedge clk) begin
      if (rst || state == QSF_CLEAR) begin
         ol_cand <= 4'hF;
      end else if (state == QSF_PROBE_ON && cnt == CNT_W'(SETTLE_WAIT - 1) && fault_n) begin
         ol_cand[idx] <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // result
   // ------------------------------------------------------------
   // with several faults the answer is meaningless; one fault assumed
   always_ff @(posedge clk) begin
      if (rst) begin
         done          <= 1'b0;
         fault_kind    <= KIND_NONE;
         fault_index   <= 2'h0;
         fault_is_pair <= 1'b0;
      end else begin
         done <= 1'b0;
         if (state == QSF_DONE) begin
            done          <= 1'b1;
            fault_is_pair <= mode;
            fault_index   <= idx;
            if (is_oc) begin
               fault_kind <= (state == QSF_DONE && fault_n) ? KIND_UNK : KIND_OC;
            end else begin
               fault_kind <= ol_cand[idx] ? KIND_OL : KIND_UNK;
               // open-load: lowest-numbered remaining suspect wins
               for (int k = 3; k >= 0; k--) begin
                  if (ol_cand[k] && (!mode || k < 2)) begin
                     fault_index <= 2'(k);
                  end
               end
               if (ol_cand == 4'h0 || (mode && ol_cand[1:0] == 2'h0)) begin
                  fault_kind <= KIND_UNK;
               end else begin
                  fault_kind <= KIND_OL;
               end
            end
         end
      end
   end

   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   // normal use passes user requests; select picks which group counts
   always_ff @(posedge clk) begin
      if (rst) begin
         drive_in   <= 4'h0;
         drive_pair <= 2'h0;
         pair_sel   <= 1'b0;
      end else if (state == QSF_IDLE && fault_n) begin
         pair_sel   <= user_pair_mode;
         drive_in   <= user_pair_mode ? 4'h0 : user_on;
         drive_pair <= user_pair_mode ? user_pair_on : 2'h0;
      end else if (state == QSF_PROBE_ON) begin
         pair_sel   <= mode;
         drive_in   <= mode ? 4'h0 : (4'h1 << idx);
         drive_pair <= mode ? (2'h1 << idx[0]) : 2'h0;
      end else begin
         // select must match the probe mode, or pair probes drive ignored pins
         pair_sel   <= (state == QSF_IDLE) ? user_pair_mode : mode;
         drive_in   <= 4'h0;
         drive_pair <= 2'h0;
      end
   end

   assign busy = (state != QSF_IDLE);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_clear_all_low: assert property (@(posedge clk) disable iff (rst)
      state == QSF_CLEAR |=> (drive_in == 4'h0 && drive_pair == 2'h0))
      else $error("inputs not low during clear");
   a_probe_one_hot: assert property (@(posedge clk) disable iff (rst)
      state == QSF_PROBE_ON && !mode |=> $onehot(drive_in) || state != QSF_PROBE_ON)
      else $error("probe drives more than one input");
   a_pair_mode_result: assert property (@(posedge clk) disable iff (rst)
      done |-> fault_is_pair == mode)
      else $error("pair flag wrong on result");
   a_idle_fault_start: assert property (@(posedge clk) disable iff (rst)
      state == QSF_IDLE && !fault_n |=> state == QSF_CLEAR)
      else $error("fault not acted on");
   a_select_follow: assert property (@(posedge clk) disable iff (rst)
      state == QSF_IDLE && fault_n |=> pair_sel == $past(user_pair_mode))
      else $error("select not passed through");
   a_probe_select: assert property (@(posedge clk) disable iff (rst)
      (state == QSF_PROBE_ON || state == QSF_PROBE_OFF) |-> pair_sel == mode)
      else $error("select differs from probe mode");
endmodule
`default_nettype wire

// file: test/qsf_dev_model.sv
// qsf_dev_model: cycle model of the quad switch fault line, seen from the pins.
// assumes the bench picks the fault kind and the faulted output while the host is idle.
`timescale 1ns/1ps
`default_nettype none
module qsf_dev_model #(
   parameter int OC_DLY   = 5,  // overcurrent_sense_delay, shortened
   parameter int SOFT_DLY = 20, // soft open report delay, shortened
   parameter int CLR_DLY  = 4   // status reset delay, below the host wait
)(
   input  wire logic       clk,
   input  wire logic [3:0] drive_in,
   input  wire logic [1:0] drive_pair,
   input  wire logic       pair_sel,
   input  wire logic [1:0] ftype,   // 0 none, 1 overcurrent, 2 open load, 3 soft open
   input  wire logic [1:0] fidx,    // faulted output
   output logic            fault_n
);
   // ------------------------------------------------------------
   // output state and report timers
   // ------------------------------------------------------------
   logic [3:0] out_on;           // output pulled low
   logic [7:0] on_cnt  = 8'h00;  // time the faulted output has been on
   logic [7:0] off_cnt = 8'h00;  // time all outputs have been off
   logic       latched = 1'b0;   // overcurrent style report held
   assign out_on = pair_sel ? {{2{drive_pair[1]}}, {2{drive_pair[0]}}} : drive_in;
   // report latches after the sense delay, clears after the reset delay
   always_ff @(posedge clk) begin
      on_cnt  <= out_on[fidx] ? on_cnt + 8'h01 : 8'h00;
      off_cnt <= (|out_on) ? 8'h00 : off_cnt + 8'h01;
      if (ftype == 2'h0 || ftype == 2'h2) begin
         latched <= 1'b0;
      end else if (out_on[fidx] && on_cnt == 8'((ftype == 2'h1) ? OC_DLY : SOFT_DLY)) begin
         latched <= 1'b1;
      end else if (off_cnt == 8'(CLR_DLY)) begin
         latched <= 1'b0;
      end
   end
   // one shared low line for every fault type; open load masked while another input is on and the faulted one is off
   always_comb begin
      if (ftype == 2'h2) begin
         fault_n = !(out_on[fidx] || out_on == 4'h0);
      end else begin
         fault_n = !latched;
      end
   end
endmodule
`default_nettype wire

// file: test/qsf_host_tb_top.sv
// qsf_host_tb_top: self-checking bench for the fault interrogation host.
// assumes the device model above; short sim waits of 8 and 40 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; $display("BAD %0t mismatch", $time); end end
module qsf_host_tb_top;
   import qsf_pkg::*;
   logic clk = 1'b0, rst = 1'b1, user_pair_mode = 1'b0, fault_n;
   logic [3:0] user_on = 4'h0, drive_in;
   logic [1:0] user_pair_on = 2'h0, drive_pair, fault_kind, fault_index, ftype = 2'h0, fidx = 2'h0;
   logic pair_sel, busy, done, fault_is_pair;
   int n_fail = 0, tests_run = 0, cyc = 0;
   qsf_host #(.RESET_WAIT(8), .SETTLE_WAIT(40)) qsf_host_inst (.clk(clk), .rst(rst), .user_on(user_on),
      .user_pair_on(user_pair_on), .user_pair_mode(user_pair_mode), .fault_n(fault_n), .drive_in(drive_in),
      .drive_pair(drive_pair), .pair_sel(pair_sel), .busy(busy), .done(done), .fault_kind(fault_kind),
      .fault_index(fault_index), .fault_is_pair(fault_is_pair));
   qsf_dev_model qsf_dev_model_inst (.clk(clk), .drive_in(drive_in), .drive_pair(drive_pair),
      .pair_sel(pair_sel), .ftype(ftype), .fidx(fidx), .fault_n(fault_n));
   initial forever #2 clk = ~clk;
   // hang guard: far above the sum of all scenarios
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d fails %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // every select level and input pattern with no fault: pins follow, line high
   task automatic nominal();
      for (int i = 0; i < 32; i++) begin
         user_pair_mode = i[4]; user_on = i[3:0]; user_pair_on = i[1:0];
         repeat (3) @(negedge clk);
         `CHK(pair_sel, i[4])
         if (i[4]) `CHK(drive_pair, i[1:0])
         else `CHK(drive_in, i[3:0])
         `CHK(fault_n, 1'b1)
      end
      user_on = 4'h0; user_pair_on = 2'h0; user_pair_mode = 1'b0;
   endtask
   // provoke a fault, drop the requests once busy, then judge the result
   task automatic run_case(input logic [3:0] on, input logic [1:0] pon, input logic pm,
      input logic [1:0] ft, input logic [1:0] fi, input logic [1:0] ek, input logic [1:0] ex, input logic ep);
      int k;
      ftype = ft; fidx = fi; user_pair_mode = pm; user_on = on; user_pair_on = pon;
      k = 0;
      while (busy !== 1'b1 && k < 200) begin @(negedge clk); k++; end
      `CHK(busy, 1'b1)
      user_on = 4'h0; user_pair_on = 2'h0;
      repeat (3) @(negedge clk);
      `CHK({drive_in, drive_pair}, 6'h00)
      k = 0;
      while (done !== 1'b1 && k < 2000) begin @(negedge clk); k++; end
      `CHK(done, 1'b1)
      `CHK(fault_kind, ek)
      `CHK(fault_index, ex)
      `CHK(fault_is_pair, ep)
      ftype = 2'h0; user_pair_mode = 1'b0;
      // a latched overcurrent may restart the host once; let that run finish
      repeat (3) @(negedge clk);
      k = 0;
      while (busy !== 1'b0 && k < 2000) begin @(negedge clk); k++; end
      `CHK(busy, 1'b0)
      repeat (20) @(negedge clk);
   endtask
   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      `CHK({drive_in, drive_pair, busy}, 7'h00)
      nominal();
      run_case(4'h4, 2'h0, 1'b0, 2'h1, 2'h2, KIND_OC, 2'h2, 1'b0);
      run_case(4'h0, 2'h0, 1'b0, 2'h2, 2'h1, KIND_OL, 2'h1, 1'b0);
      run_case(4'h8, 2'h0, 1'b0, 2'h3, 2'h3, KIND_OC, 2'h3, 1'b0);
      run_case(4'h0, 2'h2, 1'b1, 2'h1, 2'h2, KIND_OC, 2'h1, 1'b1);
      run_case(4'h0, 2'h0, 1'b1, 2'h2, 2'h0, KIND_OL, 2'h0, 1'b1);
      run_case(4'h0, 2'h0, 1'b1, 2'h2, 2'h2, KIND_OL, 2'h1, 1'b1);
      wrap_up();
   end
endmodule
`default_nettype wire
